// ---- rtl/spl_top.v ----
// Implementation choices: the APB register port and the placing of the registers.

`include "spl_defines.vh"

`default_nettype none

module spl_top (
  input  wire        clk_i,
  input  wire        srst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // serial pins, sampled as bit streams
  input  wire [3:0]  primary_serial_in_i,
  input  wire [3:0]  secondary_serial_in_i,
  // internal transmit streams and amplitude monitors
  input  wire [3:0]  tx_serial_i,
  input  wire [31:0] rx_amplitude_i,
  // to the recovery circuits and the drivers
  output wire [3:0]  clock_data_recovery_in_o,
  output wire [3:0]  primary_serial_out_o,
  output wire [3:0]  secondary_serial_out_o,
  output wire [3:0]  primary_driver_power_o,
  output wire [3:0]  secondary_driver_power_o,
  output wire [3:0]  signal_valid_o
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  reg  [3:0] pri_meta_q;
  reg  [3:0] pri_sync_q;
  reg  [3:0] sec_meta_q;
  reg  [3:0] sec_sync_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      pri_meta_q <= 4'h0;
      pri_sync_q <= 4'h0;
      sec_meta_q <= 4'h0;
      sec_sync_q <= 4'h0;
    end else begin
      pri_meta_q <= primary_serial_in_i;
      pri_sync_q <= pri_meta_q;
      sec_meta_q <= secondary_serial_in_i;
      sec_sync_q <= sec_meta_q;
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  reg  [3:0] rx_input_select_q;
  reg        all_port_loopback_q;
  reg        out_enable_latch_gate_q;
  reg  [1:0] signal_detect_level_select_q;
  reg  [7:0] shared_enable_bus_q;
  reg  [7:0] held_enable_q;
  reg  [3:0] loss_seen_q;

  wire [3:0] rx_input_select_ch_a;
  wire       acc_w;
  wire       wr_w;
  wire       hit_ctrl_w;
  wire       hit_enbus_w;
  wire       hit_loss_w;

  assign rx_input_select_ch_a = rx_input_select_q;
  assign acc_w       = psel_i & penable_i & pready_o;
  assign wr_w        = acc_w & pwrite_i;
  assign hit_ctrl_w  = (paddr_i == `SPL_OFS_CTRL);
  assign hit_enbus_w = (paddr_i == `SPL_OFS_ENBUS);
  assign hit_loss_w  = (paddr_i == `SPL_OFS_LOSS);

  // writes land on the access edge; the new level drives the paths
  // on the following edge (the detect level one edge later, through thr_q), no pin sampling delay in between
  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_input_select_q            <= `SPL_RST_SEL;
      all_port_loopback_q          <= `SPL_RST_LOOP;
      out_enable_latch_gate_q      <= `SPL_RST_GATE;
      signal_detect_level_select_q <= `SPL_RST_LVL;
      shared_enable_bus_q          <= `SPL_RST_ENBUS;
    end else if (wr_w) begin
      if (hit_ctrl_w) begin
        rx_input_select_q <= pwdata_i[`SPL_CTRL_SEL_MSB:`SPL_CTRL_SEL_LSB];
        all_port_loopback_q          <= pwdata_i[`SPL_CTRL_LOOP];
        out_enable_latch_gate_q      <= pwdata_i[`SPL_CTRL_GATE];
        signal_detect_level_select_q <= pwdata_i[`SPL_CTRL_LVL_MSB:`SPL_CTRL_LVL_LSB];
      end
      if (hit_enbus_w) begin
        shared_enable_bus_q <= pwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // output enable latch
  // ==========================================================
  // the held copy follows the bus while the gate is open, so on
  // the falling gate it keeps the last bus value seen before it
  always @(posedge clk_i) begin
    if (srst_i) begin
      held_enable_q <= `SPL_RST_HELD;
    end else if (out_enable_latch_gate_q) begin
      held_enable_q <= shared_enable_bus_q;
    end
  end

  wire [7:0] drv_en_w;
  assign drv_en_w = out_enable_latch_gate_q ? shared_enable_bus_q
                                            : held_enable_q;

  // ==========================================================
  // amplitude threshold select
  // ==========================================================
  reg  [7:0] thr_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      thr_q <= `SPL_THR_MID;
    end else begin
      case (signal_detect_level_select_q)
        `SPL_LVL_LOW:  thr_q <= `SPL_THR_LOW;
        `SPL_LVL_HIGH: thr_q <= `SPL_THR_HIGH;
        default:       thr_q <= `SPL_THR_MID;
      endcase
    end
  end

  // ==========================================================
  // channels
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      spl_chan u_chan (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .pri_in_i    (pri_sync_q[gi]),
        .sec_in_i    (sec_sync_q[gi]),
        .tx_bit_i    (tx_serial_i[gi]),
        .sel_i       (rx_input_select_ch_a[gi]),
        .loop_i      (all_port_loopback_q),
        .en_pri_i    (drv_en_w[2*gi]),
        .en_sec_i    (drv_en_w[2*gi+1]),
        .amp_i       (rx_amplitude_i[8*gi+7:8*gi]),
        .thr_i       (thr_q),
        .cdr_in_o    (clock_data_recovery_in_o[gi]),
        .out_pri_o   (primary_serial_out_o[gi]),
        .out_sec_o   (secondary_serial_out_o[gi]),
        .pwr_pri_o   (primary_driver_power_o[gi]),
        .pwr_sec_o   (secondary_driver_power_o[gi]),
        .sig_valid_o (signal_valid_o[gi])
      );
    end
  endgenerate

  // ==========================================================
  // loss of signal history
  // ==========================================================
  // sticky: a loss in the same cycle as a write-one clear survives
  wire [3:0] loss_clr_w;
  assign loss_clr_w = (wr_w & hit_loss_w) ? pwdata_i[3:0] : 4'h0;

  always @(posedge clk_i) begin
    if (srst_i) begin
      loss_seen_q <= 4'h0;
    end else begin
      loss_seen_q <= (loss_seen_q & ~loss_clr_w) | ~signal_valid_o;
    end
  end

  // ==========================================================
  // apb read mux and handshake
  // ==========================================================
  reg  [31:0] rd_d;
  reg         err_d;

  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr_i)
      `SPL_OFS_CTRL: begin
        rd_d[`SPL_CTRL_SEL_MSB:`SPL_CTRL_SEL_LSB] = rx_input_select_q;
        rd_d[`SPL_CTRL_LOOP]                      = all_port_loopback_q;
        rd_d[`SPL_CTRL_GATE]                      = out_enable_latch_gate_q;
        rd_d[`SPL_CTRL_LVL_MSB:`SPL_CTRL_LVL_LSB] = signal_detect_level_select_q;
      end
      `SPL_OFS_ENBUS: begin
        rd_d[7:0] = shared_enable_bus_q;
      end
      `SPL_OFS_STATUS: begin
        rd_d[`SPL_STAT_PWR_MSB:`SPL_STAT_PWR_LSB] = drv_en_w;
        rd_d[`SPL_STAT_SV_MSB:`SPL_STAT_SV_LSB]   = signal_valid_o;
        rd_d[`SPL_STAT_LOOP]                      = all_port_loopback_q;
        rd_d[`SPL_STAT_GATE]                      = out_enable_latch_gate_q;
      end
      `SPL_OFS_PINS: begin
        rd_d[3:0] = pri_sync_q;
        rd_d[7:4] = sec_sync_q;
      end
      `SPL_OFS_LOSS: begin
        rd_d[3:0] = loss_seen_q;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // one access cycle: pready rises the edge after setup, drops after
  always @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (psel_i & ~penable_i) begin
      pready_o  <= 1'b1;
      pslverr_o <= err_d;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_d;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/spl_defines.vh ----
`ifndef SPL_DEFINES_VH
`define SPL_DEFINES_VH

// ==========================================================
// register offsets (byte addresses)
// ==========================================================
`define SPL_OFS_CTRL      12'h000
`define SPL_OFS_ENBUS     12'h004
`define SPL_OFS_STATUS    12'h008
`define SPL_OFS_PINS      12'h00C
`define SPL_OFS_LOSS      12'h010

// ==========================================================
// control register fields
// ==========================================================
`define SPL_CTRL_SEL_LSB  0
`define SPL_CTRL_SEL_MSB  3
`define SPL_CTRL_LOOP     4
`define SPL_CTRL_GATE     5
`define SPL_CTRL_LVL_LSB  8
`define SPL_CTRL_LVL_MSB  9

// ==========================================================
// status register fields
// ==========================================================
`define SPL_STAT_PWR_LSB  0
`define SPL_STAT_PWR_MSB  7
`define SPL_STAT_SV_LSB   8
`define SPL_STAT_SV_MSB   11
`define SPL_STAT_LOOP     12
`define SPL_STAT_GATE     13

// ==========================================================
// reset values
// ==========================================================
`define SPL_RST_SEL       4'hF
`define SPL_RST_LOOP      1'h0
`define SPL_RST_GATE      1'h0
`define SPL_RST_LVL       2'h1
`define SPL_RST_ENBUS     8'h00
`define SPL_RST_HELD      8'h00

// ==========================================================
// signal detect level codes and amplitude thresholds
// ==========================================================
`define SPL_LVL_LOW       2'h0
`define SPL_LVL_MID       2'h1
`define SPL_LVL_HIGH      2'h2
`define SPL_THR_LOW       8'h20
`define SPL_THR_MID       8'h40
`define SPL_THR_HIGH      8'h80

`endif

// ---- rtl/spl_chan.v ----
`default_nettype none

// ==========================================================
// one channel: receive input choice, loopback, two drivers
// ==========================================================
module spl_chan (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       pri_in_i,
  input  wire       sec_in_i,
  input  wire       tx_bit_i,
  input  wire       sel_i,
  input  wire       loop_i,
  input  wire       en_pri_i,
  input  wire       en_sec_i,
  input  wire [7:0] amp_i,
  input  wire [7:0] thr_i,
  output reg        cdr_in_o,
  output reg        out_pri_o,
  output reg        out_sec_o,
  output reg        pwr_pri_o,
  output reg        pwr_sec_o,
  output reg        sig_valid_o
);

  reg cdr_d;
  reg out_pri_d;
  reg out_sec_d;

  always @* begin
    // loopback wins over both external inputs
    if (loop_i) begin
      cdr_d = tx_bit_i;
    end else if (sel_i) begin
      cdr_d = pri_in_i;
    end else begin
      cdr_d = sec_in_i;
    end
    // a powered-down driver is parked low
    out_pri_d = en_pri_i & (loop_i | tx_bit_i);
    out_sec_d = en_sec_i & (loop_i | tx_bit_i);
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      cdr_in_o    <= 1'b0;
      out_pri_o   <= 1'b0;
      out_sec_o   <= 1'b0;
      pwr_pri_o   <= 1'b0;
      pwr_sec_o   <= 1'b0;
      sig_valid_o <= 1'b0;
    end else begin
      cdr_in_o    <= cdr_d;
      out_pri_o   <= out_pri_d;
      out_sec_o   <= out_sec_d;
      pwr_pri_o   <= en_pri_i;
      pwr_sec_o   <= en_sec_i;
      sig_valid_o <= (amp_i >= thr_i);
    end
  end

endmodule

`default_nettype wire

// ---- verif/spl_top_properties.sv ----
`default_nettype none

module spl_top_properties (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] rx_amplitude_i,
  input wire logic [3:0]  primary_serial_out_o,
  input wire logic [3:0]  secondary_serial_out_o,
  input wire logic [3:0]  primary_driver_power_o,
  input wire logic [3:0]  secondary_driver_power_o,
  input wire logic [3:0]  signal_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc_write;

  assign acc_write = psel_i && penable_i && pwrite_i && pready_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // ==========================================================
  // register bus
  // ==========================================================
  setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");

  // ==========================================================
  // drivers and signal detect
  // ==========================================================
  pri_quiet_a: assert property ((primary_serial_out_o & ~primary_driver_power_o) == 4'h0)
    else $error("unpowered primary driver sends data");
  sec_quiet_a: assert property ((secondary_serial_out_o & ~secondary_driver_power_o) == 4'h0)
    else $error("unpowered secondary driver sends data");
  reset_off_a: assert property (disable iff (1'b0) srst_i |=>
    {primary_driver_power_o, secondary_driver_power_o} == 8'h00)
    else $error("drivers on after reset");
  // enables only move after reset or a register write, never on their own
  // a write lands at one edge and the driver enable register follows one edge later
  power_cause_a: assert property ($changed({primary_driver_power_o,
    secondary_driver_power_o}) |-> $past(srst_i) || $past(acc_write, 2))
    else $error("driver enable changed without cause");
  valid_high_a: assert property (!$past(srst_i) && $past(rx_amplitude_i[23:16]) >= 8'h80
    |-> signal_valid_o[2])
    else $error("strong signal not valid");
  valid_low_a: assert property (!$past(srst_i) && $past(rx_amplitude_i[31:24]) < 8'h20
    |-> !signal_valid_o[3])
    else $error("weak signal valid");
endmodule

`default_nettype wire

// ---- verif/spl_cable.sv ----
`default_nettype none

// ==========================================================
// far side cable: steady levels, or a toggling dark line
// ==========================================================
module spl_cable (
  input  wire logic       clk_i,
  input  wire logic       dark_i,
  input  wire logic [3:0] pri_val_i,
  input  wire logic [3:0] sec_val_i,
  output var  logic [3:0] primary_serial_in_o,
  output var  logic [3:0] secondary_serial_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tgl_q = 1'b0;

  // a dark line is noise, so it changes every cycle rather than holding
  always @(posedge clk_i) begin
    tgl_q <= ~tgl_q;
    primary_serial_in_o <= dark_i ? {4{tgl_q}} : pri_val_i;
    secondary_serial_in_o <= dark_i ? ~{4{tgl_q}} : sec_val_i;
  end
endmodule

`default_nettype wire

// ---- verif/tb_spl_top.sv ----
`include "spl_defines.vh"

`default_nettype none

module tb_spl_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  tx_serial_i = 4'h0;
  logic [31:0] rx_amplitude_i = 32'h0;
  logic        dark = 1'b0;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o;
  wire  [3:0]  pri_in, sec_in, clock_data_recovery, pri_out, sec_out, pri_pwr, sec_pwr, valid;
  int          num_errors = 0;
  int          check_count = 0;

  always #20 clk_i = ~clk_i;

  spl_top DUT (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .primary_serial_in_i(pri_in),
    .secondary_serial_in_i(sec_in), .tx_serial_i(tx_serial_i),
    .rx_amplitude_i(rx_amplitude_i), .clock_data_recovery_in_o(clock_data_recovery),
    .primary_serial_out_o(pri_out), .secondary_serial_out_o(sec_out),
    .primary_driver_power_o(pri_pwr), .secondary_driver_power_o(sec_pwr),
    .signal_valid_o(valid));
  spl_cable u_cable (.clk_i(clk_i), .dark_i(dark), .pri_val_i(4'h5), .sec_val_i(4'hA),
    .primary_serial_in_o(pri_in), .secondary_serial_in_o(sec_in));

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one idle edge after each transfer keeps psel from being set twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "no ready");
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    apb(1'b0, `SPL_OFS_CTRL, 32'h0);
    chk(rd, {`SPL_RST_LVL, 2'h0, `SPL_RST_GATE, `SPL_RST_LOOP, `SPL_RST_SEL}, "ctrl");
    apb(1'b0, `SPL_OFS_ENBUS, 32'h0);
    chk(rd, `SPL_RST_ENBUS, "enable bus");
    chk({sec_pwr, pri_pwr}, 8'h00, "drivers after reset");
    apb(1'b0, 12'h014, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
    $display("t_reset done");
  endtask

  task automatic t_select();
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_0103);
    repeat (5) @(posedge clk_i);
    chk(clock_data_recovery, 4'b1001, "select 0011");
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_010C);
    repeat (5) @(posedge clk_i);
    chk(clock_data_recovery, 4'b0110, "select 1100");
    $display("t_select done");
  endtask

  task automatic t_latch();
    tx_serial_i <= 4'hF;
    // bus bits 2n and 2n+1 both land on channel n, so 0F shows as 33
    apb(1'b1, `SPL_OFS_ENBUS, 32'h0F);
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_012F);
    repeat (3) @(posedge clk_i);
    chk({sec_pwr, pri_pwr}, 8'h33, "bus mapping");
    chk({sec_out, pri_out}, 8'h33, "enabled drivers send");
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_010F);
    apb(1'b1, `SPL_OFS_ENBUS, 32'hF0);
    repeat (3) @(posedge clk_i);
    chk({sec_pwr, pri_pwr}, 8'h33, "latched");
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_012F);
    repeat (3) @(posedge clk_i);
    chk({sec_pwr, pri_pwr}, 8'hCC, "transparent again");
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({sec_pwr, pri_pwr}, 8'h00, "reset clears latch");
    $display("t_latch done");
  endtask

  task automatic t_loop();
    dark <= 1'b1;
    tx_serial_i <= 4'b0110;
    apb(1'b1, `SPL_OFS_ENBUS, 32'hFF);
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_0135);
    repeat (4) @(posedge clk_i);
    chk(clock_data_recovery, 4'b0110, "loop path");
    chk({sec_out, pri_out}, 8'hFF, "loop drives ones");
    tx_serial_i <= 4'b1001;
    repeat (3) @(posedge clk_i);
    chk(clock_data_recovery, 4'b1001, "loop follows tx");
    dark <= 1'b0;
    apb(1'b1, `SPL_OFS_CTRL, 32'h0000_010F);
    $display("t_loop done");
  endtask

  task automatic t_level();
    logic [3:0] exp_v [4];
    exp_v = '{4'h7, 4'h6, 4'h4, 4'h6};
    rx_amplitude_i <= 32'h1090_5030;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SPL_OFS_CTRL, {22'h0, i[1:0], 8'h0F});
      repeat (4) @(posedge clk_i);
      chk(valid, exp_v[i], "signal detect level");
    end
    $display("t_level done");
  endtask

  // read-only views: held enables FF, level 3 acts as mid, pins idle at 5 and A
  task automatic t_status();
    apb(1'b0, `SPL_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_06FF, "status");
    apb(1'b0, `SPL_OFS_PINS, 32'h0);
    chk(rd, 32'h0000_00A5, "synced pins");
    apb(1'b1, `SPL_OFS_LOSS, 32'h0000_000F);
    apb(1'b0, `SPL_OFS_LOSS, 32'h0);
    chk(rd, 32'h0000_0009, "loss after clear");
    $display("t_status done");
  endtask

  // ==========================================================
  // sequence and watchdog
  // ==========================================================
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_select();
    t_latch();
    t_loop();
    t_level();
    t_status();
    give_verdict();
  end

  // the whole run needs a little over a hundred cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    chk(32'h0, 32'h1, "watchdog");
    give_verdict();
  end
endmodule

bind spl_top spl_top_properties u_props (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
  .prdata_o, .pready_o, .pslverr_o, .rx_amplitude_i, .primary_serial_out_o,
  .secondary_serial_out_o, .primary_driver_power_o, .secondary_driver_power_o,
  .signal_valid_o);

`default_nettype wire
